// ### fci_pkg.sv
package fci_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry and register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_INSTR  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Instruction word fields and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned OPC_LSB  = 0;
  localparam int unsigned OPC_W    = 5;
  localparam int unsigned IDX_LSB  = 5;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned DAT_LSB  = 8;
  localparam int unsigned DAT_W    = 8;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned CTRL_DBG = 0;

  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // Bit positions inside the processor flags register.
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE_INSTRUCTION    = 5'h00,
    OP_INDEXED_FLAG_RAISE  = 5'h01,
    OP_INDEXED_FLAG_LOWER  = 5'h02,
    OP_REG_BIT_TO_FLAG     = 5'h03,
    OP_FLAG_TO_REG_BIT     = 5'h04,
    OP_NIBBLE_SWAP         = 5'h05,
    OP_SLEEP               = 5'h06,
    OP_WATCHDOG_RESTART_OP = 5'h07,
    OP_BREAK               = 5'h08,
    OP_CARRY_LOWER         = 5'h10,
    OP_CARRY_RAISE         = 5'h11,
    OP_ZERO_LOWER          = 5'h12,
    OP_ZERO_RAISE          = 5'h13,
    OP_NEGATIVE_LOWER      = 5'h14,
    OP_NEGATIVE_RAISE      = 5'h15,
    OP_OVERFLOW_FLAG_LOWER = 5'h16,
    OP_OVERFLOW_FLAG_RAISE = 5'h17,
    OP_SIGN_FLAG_LOWER     = 5'h18,
    OP_SIGN_FLAG_RAISE     = 5'h19,
    OP_HALF_CARRY_LOWER    = 5'h1A,
    OP_HALF_CARRY_RAISE    = 5'h1B,
    OP_TRANSFER_FLAG_LOWER = 5'h1C,
    OP_TRANSFER_FLAG_RAISE = 5'h1D,
    OP_IRQ_GLOBAL_OFF      = 5'h1E,
    OP_IRQ_GLOBAL_ON       = 5'h1F
  } fci_op_t;

  // Replaces one bit of a byte; used for flag and register bit updates.
  function automatic logic [7:0] fci_put_bit(input logic [7:0] v, input logic [2:0] i, input logic b);
    logic [7:0] r;
    r    = v;
    r[i] = b;
    return r;
  endfunction

endpackage

// ### fci_exec.sv
`timescale 1ns/1ps
module fci_exec
  import fci_pkg::*;
(
  input  wire logic [OPC_W-1:0] op,          // Operation code.
  input  wire logic [2:0]       idx,         // Bit or flag index.
  input  wire logic [7:0]       data,        // Register operand.
  input  wire logic [7:0]       flags,       // Current processor flags.
  input  wire logic             dbg_en,      // Debug system present.
  output logic      [7:0]       flags_next,  // Flags after the instruction.
  output logic      [7:0]       result,      // Register result.
  output logic                  result_we,   // Result is to be stored.
  output logic                  sleep_go,    // Sleep hand-off.
  output logic                  wdr_go,      // Watchdog restart.
  output logic                  brk_go       // Debug break.
);

  // ---------------------------------------------------------------------------
  // Single-cycle execution of one instruction
  // ---------------------------------------------------------------------------
  // Every path starts from "nothing changes" so that, apart from the nibble swap, only the addressed bit moves.
  always_comb begin
    flags_next = flags;
    result     = data;
    result_we  = 1'b0;
    sleep_go   = 1'b0;
    wdr_go     = 1'b0;
    brk_go     = 1'b0;
    if (op[4]) begin
      // Dedicated set/clear codes carry the flag index in bits 3..1.
      flags_next = fci_put_bit(flags, op[3:1], op[0]);
    end else begin
      unique case (op)
        OP_INDEXED_FLAG_RAISE: flags_next = fci_put_bit(flags, idx, 1'b1);
        OP_INDEXED_FLAG_LOWER: flags_next = fci_put_bit(flags, idx, 1'b0);
        OP_REG_BIT_TO_FLAG:    flags_next = fci_put_bit(flags, FLG_T, data[idx]);
        OP_FLAG_TO_REG_BIT: begin
          result    = fci_put_bit(data, idx, flags[FLG_T]);
          result_we = 1'b1;
        end
        OP_NIBBLE_SWAP: begin
          result    = {data[3:0], data[7:4]};
          result_we = 1'b1;
        end
        OP_SLEEP:               sleep_go = 1'b1;
        OP_WATCHDOG_RESTART_OP: wdr_go   = 1'b1;
        OP_BREAK:               brk_go   = dbg_en;
        default:                flags_next = flags; // Idle and undefined codes change nothing
      endcase
    end
  end

endmodule

// ### fci_top.sv
// Behaviour
// - Indexed raise and lower force the status bit chosen by a 3-bit index to one or zero in one clock, alone.
// - Register-bit-to-flag copies bit b of the operand into the transfer flag in one clock.
// - Flag-to-register-bit writes the transfer flag into bit b of the result, nothing else changing, in one clock.
// - Overflow raise and lower set and clear only the overflow flag, each in one clock.
// - Half-carry raise and lower set and clear only the half-carry flag, each in one clock.
// - Sign raise and lower set and clear only the signed-test flag, each in one clock.
// - Sleep takes one clock, leaves the flags alone and hands off to the sleep controller.
// - Watchdog restart takes one clock, leaves the flags alone and tells the watchdog to restart.
// - Break acts only when the debug system is present and never changes the flags.
`timescale 1ns/1ps
module fci_top
  import fci_pkg::*;
(
  input  wire logic              aclk,             // Core clock, 10 MHz.
  input  wire logic              aresetn,          // Synchronous reset, low active.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address.
  input  wire logic              s_axi_awvalid,    // Write address valid.
  output logic                   s_axi_awready,    // Write address ready.
  input  wire logic [DATA_W-1:0] s_axi_wdata,      // Write data.
  input  wire logic [3:0]        s_axi_wstrb,      // Write byte strobes.
  input  wire logic              s_axi_wvalid,     // Write data valid.
  output logic                   s_axi_wready,     // Write data ready.
  output logic [1:0]             s_axi_bresp,      // Write response.
  output logic                   s_axi_bvalid,     // Write response valid.
  input  wire logic              s_axi_bready,     // Write response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address.
  input  wire logic              s_axi_arvalid,    // Read address valid.
  output logic                   s_axi_arready,    // Read address ready.
  output logic [DATA_W-1:0]      s_axi_rdata,      // Read data.
  output logic [1:0]             s_axi_rresp,      // Read response.
  output logic                   s_axi_rvalid,     // Read data valid.
  input  wire logic              s_axi_rready,     // Read data ready.
  output logic [7:0]             processor_flags,  // Processor flags register.
  output logic                   sleep_req,        // One-cycle sleep hand-off.
  output logic                   wdog_restart,     // One-cycle watchdog restart.
  output logic                   debug_break       // One-cycle debug break.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic [7:0]        flags;
    logic [7:0]        result;
    logic              dbg_en;
    logic [CNT_W-1:0]  count;
    logic              sleep;
    logic              watchdog_restart_op;
    logic              brk;
  } fci_state_t;

  fci_state_t st_q;
  fci_state_t st_d;

  logic             exec_go;
  logic [OPC_W-1:0] exec_op;
  logic [2:0]       exec_idx;
  logic [7:0]       exec_data;
  logic [7:0]       flags_next;
  logic [7:0]       exec_result;
  logic             exec_we;
  logic             sleep_go;
  logic             wdr_go;
  logic             brk_go;
  logic             wr_fire;

  // Instruction fields come straight from the captured write data.
  assign exec_op   = st_q.w_data[OPC_LSB +: OPC_W];
  assign exec_idx  = st_q.w_data[IDX_LSB +: IDX_W];
  assign exec_data = st_q.w_data[DAT_LSB +: DAT_W];
  assign wr_fire   = st_q.aw_full && st_q.w_full && !st_q.bvalid;
  // The low byte holds the opcode, so an instruction only issues when it is strobed.
  assign exec_go   = wr_fire && (st_q.aw_addr == OFS_INSTR) && st_q.w_strb[0];

  fci_exec u_exec (
    .op         (exec_op),
    .idx        (exec_idx),
    .data       (exec_data),
    .flags      (st_q.flags),
    .dbg_en     (st_q.dbg_en),
    .flags_next (flags_next),
    .result     (exec_result),
    .result_we  (exec_we),
    .sleep_go   (sleep_go),
    .wdr_go     (wdr_go),
    .brk_go     (brk_go)
  );

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  function automatic logic [DATA_W+1:0] rd_decode(input fci_state_t s, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    d = '0;
    r = RESP_OKAY;
    unique case (a)
      OFS_INSTR:  d = s.w_data;
      OFS_FLAGS:  d[7:0] = s.flags;
      OFS_RESULT: d[7:0] = s.result;
      OFS_CTRL:   d[CTRL_DBG] = s.dbg_en;
      OFS_COUNT:  d[CNT_W-1:0] = s.count;
      default:    r = RESP_SLVERR;
    endcase
    return {r, d};
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Address and data are held separately, so the master may offer them in any order.
  always_comb begin
    st_d       = st_q;
    st_d.sleep = 1'b0;
    st_d.watchdog_restart_op   = 1'b0;
    st_d.brk   = 1'b0;
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_full = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      unique case (st_q.aw_addr)
        OFS_INSTR:  st_d.bresp = RESP_OKAY;
        OFS_FLAGS:  if (st_q.w_strb[0]) st_d.flags = st_q.w_data[7:0];
        OFS_CTRL:   if (st_q.w_strb[0]) st_d.dbg_en = st_q.w_data[CTRL_DBG];
        OFS_RESULT: st_d.bresp = RESP_SLVERR;
        OFS_COUNT:  st_d.bresp = RESP_SLVERR;
        default:    st_d.bresp = RESP_SLVERR;
      endcase
    end
    // Execution finishes in the cycle the held instruction write fires, one cycle after the word is taken.
    if (exec_go) begin
      st_d.flags = flags_next;
      if (exec_we) begin
        st_d.result = exec_result;
      end
      st_d.sleep = sleep_go;
      st_d.watchdog_restart_op   = wdr_go;
      st_d.brk   = brk_go;
      st_d.count = st_q.count + CNT_W'(1);
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid                 = 1'b1;
      {st_d.rresp, st_d.rdata}    = rd_decode(st_q, s_axi_araddr);
    end
    // Ready is registered, so it is derived from the state the next cycle will hold.
    st_d.awready = !st_d.aw_full && !st_d.bvalid;
    st_d.wready  = !st_d.w_full && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  // Register the whole state; reset leaves the bus idle and the flags cleared.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.flags  <= FLAGS_RST;
      st_q.result <= RESULT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign s_axi_awready   = st_q.awready;
  assign s_axi_wready    = st_q.wready;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_arready   = st_q.arready;
  assign s_axi_rvalid    = st_q.rvalid;
  assign s_axi_rresp     = st_q.rresp;
  assign s_axi_rdata     = st_q.rdata;
  assign processor_flags = st_q.flags;
  assign sleep_req       = st_q.sleep;
  assign wdog_restart    = st_q.watchdog_restart_op;
  assign debug_break     = st_q.brk;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idx_raise: assert property (exec_go && exec_op == OP_INDEXED_FLAG_RAISE |=>
    st_q.flags == ($past(st_q.flags) | (8'h01 << $past(exec_idx))))
    else $error("indexed raise did not set exactly one flag");
  a_idx_lower: assert property (exec_go && exec_op == OP_INDEXED_FLAG_LOWER |=>
    st_q.flags == ($past(st_q.flags) & ~(8'h01 << $past(exec_idx))))
    else $error("indexed lower did not clear exactly one flag");
  a_bit_to_flag: assert property (exec_go && exec_op == OP_REG_BIT_TO_FLAG |=>
    st_q.flags[FLG_T] == $past(exec_data[exec_idx]))
    else $error("transfer flag not loaded from operand bit");
  a_flag_to_bit: assert property (exec_go && exec_op == OP_FLAG_TO_REG_BIT |=>
    st_q.result[$past(exec_idx)] == $past(st_q.flags[FLG_T]) && st_q.flags == $past(st_q.flags))
    else $error("operand bit not loaded from transfer flag");
  a_overflow_set: assert property (exec_go && exec_op == OP_OVERFLOW_FLAG_RAISE |=>
    st_q.flags == fci_put_bit($past(st_q.flags), FLG_V, 1'b1))
    else $error("overflow raise wrong");
  a_half_clear: assert property (exec_go && exec_op == OP_HALF_CARRY_LOWER |=>
    st_q.flags == fci_put_bit($past(st_q.flags), FLG_H, 1'b0))
    else $error("half-carry lower wrong");
  a_sign_set: assert property (exec_go && exec_op == OP_SIGN_FLAG_RAISE |=>
    st_q.flags == fci_put_bit($past(st_q.flags), FLG_S, 1'b1))
    else $error("sign raise wrong");
  a_sleep_pulse: assert property (exec_go && exec_op == OP_SLEEP |=>
    sleep_req && $stable(st_q.flags) ##1 !sleep_req)
    else $error("sleep hand-off not a single pulse");
  a_wdr_pulse: assert property (wdog_restart |-> $past(exec_go && exec_op == OP_WATCHDOG_RESTART_OP))
    else $error("watchdog restart without its instruction");
  a_break_gate: assert property (debug_break |-> $past(st_q.dbg_en) && $stable(st_q.flags))
    else $error("break acted without debug system");
  a_irq_on: assert property (exec_go && exec_op == OP_IRQ_GLOBAL_ON |=>
    st_q.flags == fci_put_bit($past(st_q.flags), FLG_I, 1'b1))
    else $error("global interrupt raise wrong");
  a_swap_nibbles: assert property (exec_go && exec_op == OP_NIBBLE_SWAP |=>
    st_q.result == {$past(exec_data[3:0]), $past(exec_data[7:4])} && $stable(st_q.flags))
    else $error("nibble swap wrong");

  c_swap: cover property (exec_go && exec_op == OP_NIBBLE_SWAP);
  c_break: cover property (exec_go && exec_op == OP_BREAK && st_q.dbg_en);
  c_idx_raise: cover property (exec_go && exec_op == OP_INDEXED_FLAG_RAISE ##[1:20] exec_go);
  c_read_flags: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_FLAGS);

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
  import fci_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals, clock and timeout
  // ---------------------------------------------------------------------------
  localparam int LIMIT = 40000;
  logic              aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp;
  logic [7:0]        pflags, res_m;
  logic              sleep_req, wdog_restart, debug_break;
  logic [31:0]       rv, rd, c0;
  logic [1:0]        rs;
  logic [2:0]        pu;
  logic [7:0]        pf;
  int                errors, num_checks, cycles;

  fci_top u_fci_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .processor_flags(pflags), .sleep_req(sleep_req), .wdog_restart(wdog_restart),
    .debug_break(debug_break)
  );

  // Free-running core clock, 100 ns period.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------------------
  // Checking and expectation helpers
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // Flags after one instruction; each dedicated code is tied to its flag by name, not by its encoding.
  function automatic logic [7:0] exp_flags(input logic [4:0] op, input logic [2:0] ix,
                                           input logic [7:0] dv, input logic [7:0] f);
    logic [7:0] n;
    n = f;
    if (op == OP_INDEXED_FLAG_RAISE) n[ix] = 1'b1;
    else if (op == OP_INDEXED_FLAG_LOWER) n[ix] = 1'b0;
    else if (op == OP_REG_BIT_TO_FLAG) n[FLG_T] = dv[ix];
    else begin
      case (op)
        OP_CARRY_LOWER, OP_CARRY_RAISE:                 n[FLG_C] = (op == OP_CARRY_RAISE);
        OP_ZERO_LOWER, OP_ZERO_RAISE:                   n[FLG_Z] = (op == OP_ZERO_RAISE);
        OP_NEGATIVE_LOWER, OP_NEGATIVE_RAISE:           n[FLG_N] = (op == OP_NEGATIVE_RAISE);
        OP_OVERFLOW_FLAG_LOWER, OP_OVERFLOW_FLAG_RAISE: n[FLG_V] = (op == OP_OVERFLOW_FLAG_RAISE);
        OP_SIGN_FLAG_LOWER, OP_SIGN_FLAG_RAISE:         n[FLG_S] = (op == OP_SIGN_FLAG_RAISE);
        OP_HALF_CARRY_LOWER, OP_HALF_CARRY_RAISE:       n[FLG_H] = (op == OP_HALF_CARRY_RAISE);
        OP_TRANSFER_FLAG_LOWER, OP_TRANSFER_FLAG_RAISE: n[FLG_T] = (op == OP_TRANSFER_FLAG_RAISE);
        OP_IRQ_GLOBAL_OFF, OP_IRQ_GLOBAL_ON:            n[FLG_I] = (op == OP_IRQ_GLOBAL_ON);
        default:                                        n = f;
      endcase
    end
    return n;
  endfunction

  // Register result; only the two register-writing codes replace the old value.
  function automatic logic [7:0] exp_res(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] dv,
                                         input logic [7:0] f, input logic [7:0] old);
    logic [7:0] n;
    n = old;
    if (op == OP_FLAG_TO_REG_BIT) begin
      n     = dv;
      n[ix] = f[FLG_T];
    end else if (op == OP_NIBBLE_SWAP) n = {dv[3:0], dv[7:4]};
    return n;
  endfunction

  // ---------------------------------------------------------------------------
  // AXI4-Lite master tasks
  // ---------------------------------------------------------------------------
  // Address and data are offered together and each is dropped once taken.
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r, output logic [2:0] p, output logic [7:0] f);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    p = {sleep_req, wdog_restart, debug_break};
    f = pflags;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Loads debug enable and flags, issues one instruction and checks its response, flags, pulses and result; the count is not checked.
  task automatic run_op(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] dv,
                        input logic [7:0] fi, input logic dbg);
    logic [7:0] ef;
    ef = exp_flags(op, ix, dv, fi);
    axi_wr(OFS_CTRL, {31'h0, dbg}, 4'hF, rs, pu, pf);
    axi_wr(OFS_FLAGS, {24'h0, fi}, 4'hF, rs, pu, pf);
    axi_wr(OFS_INSTR, {16'h0, dv, ix, op}, 4'hF, rs, pu, pf);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    chk({24'h0, pf}, {24'h0, ef});
    chk({29'h0, pu}, {29'h0, op == OP_SLEEP, op == OP_WATCHDOG_RESTART_OP, op == OP_BREAK && dbg});
    res_m = exp_res(op, ix, dv, fi, res_m);
    axi_rd(OFS_RESULT, rd, rs);
    chk(rd, {24'h0, res_m});
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    axi_rd(OFS_FLAGS, rd, rs);
    chk(rd, {24'h0, ef});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    errors     = 0;
    num_checks = 0;
    cycles     = 0;
    res_m      = RESULT_RST;
    void'($urandom(32'hFB8AEBF6));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({24'h0, pflags}, {24'h0, FLAGS_RST});
    axi_rd(OFS_RESULT, rd, rs);
    chk(rd, {24'h0, RESULT_RST});
    axi_rd(OFS_COUNT, rd, rs);
    chk(rd, 32'h0);
    $display("test reset done");
    // Every code, once with the debug system absent and once present.
    for (int k = 0; k < 64; k++) begin
      rv = $urandom;
      run_op(k[4:0], rv[2:0], rv[15:8], rv[23:16], k[5]);
    end
    $display("test all codes done");
    repeat (200) begin
      rv = $urandom;
      run_op(rv[4:0], rv[7:5], rv[15:8], rv[23:16], rv[24]);
    end
    $display("test random codes done");
    // A gated write must not execute; three idle instructions count and change nothing.
    axi_rd(OFS_COUNT, c0, rs);
    axi_wr(OFS_FLAGS, 32'h5A, 4'hF, rs, pu, pf);
    axi_wr(OFS_INSTR, {27'h0, OP_SLEEP}, 4'hE, rs, pu, pf);
    chk({29'h0, pu}, 32'h0);
    repeat (3) begin
      axi_wr(OFS_INSTR, {27'h0, OP_IDLE_INSTRUCTION}, 4'hF, rs, pu, pf);
      chk({24'h0, pf}, 32'h5A);
      chk({29'h0, pu}, 32'h0);
    end
    axi_rd(OFS_INSTR, rd, rs);
    chk(rd, {27'h0, OP_IDLE_INSTRUCTION});
    axi_rd(OFS_COUNT, rd, rs);
    chk(rd, {16'h0, c0[15:0] + 16'h3});
    $display("test gating and count done");
    // A reset in mid-run returns flags, result, debug enable and count to their reset values.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({24'h0, pflags}, {24'h0, FLAGS_RST});
    axi_rd(OFS_COUNT, rd, rs);
    chk(rd, 32'h0);
    res_m = RESULT_RST;
    axi_rd(OFS_CTRL, rd, rs);
    chk(rd, 32'h0);
    axi_wr(OFS_CTRL, 32'h1, 4'hF, rs, pu, pf);
    axi_rd(OFS_CTRL, rd, rs);
    chk(rd, 32'h1);
    $display("test mid-run reset done");
    // Unmapped and read-only places answer with an error and change nothing.
    axi_wr(5'h14, 32'hFFFFFFFF, 4'hF, rs, pu, pf);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_rd(5'h14, rd, rs);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_RESULT, 32'hFFFFFFFF, 4'hF, rs, pu, pf);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_rd(OFS_RESULT, rd, rs);
    chk(rd, {24'h0, res_m});
    $display("test unmapped done");
    complete_run();
  end
endmodule
